// file: inc/rlc_params.svh
// Constants for the receiver lane control block
`ifndef RLC_PARAMS_SVH
`define RLC_PARAMS_SVH
// Datapath geometry
`define RLC_WORD_W 40
`define RLC_SYM_W 10
`define RLC_SYMS 4
`define RLC_LANES 4
`define RLC_OFF_W 6
`define RLC_ADDR_W 12
// Register byte addresses
`define RLC_COMMON_OFFSET 12'h000
`define RLC_FIRST_LANE_OFFSET 12'h004
`define RLC_STATUS_OFFSET 12'h040
// Generation-time ordering choices
`define RLC_BIT_REVERSAL 1'b1
`define RLC_OCTET_REVERSAL 1'b1
// Field positions, common word
`define RLC_COMMON_SPARE_BIT 2
`define RLC_COMMON_BITREV_BIT 1
`define RLC_COMMON_OCTREV_BIT 0
// Field positions, first lane word
`define RLC_LANE_ALIGN_BIT 2
`define RLC_LANE_PWR_BIT 1
`define RLC_LANE_INV_BIT 0
// Field positions, status word
`define RLC_STAT_BYPASS_BIT 9
`define RLC_STAT_LOCK_BIT 8
`define RLC_STAT_OFF_LSB 0
// Reset values
`define RLC_COMMON_SPARE_RST 1'b0
`define RLC_LANE_ALIGN_RST 1'b1
`define RLC_LANE_PWR_RST 1'b0
`define RLC_LANE_INV_RST 1'b0
// Alignment pattern, both running disparities
`define RLC_COMMA_POS 10'h0FA
`define RLC_COMMA_NEG 10'h305
`endif

// file: inc/rlc_pkg.sv
// Types shared by the receiver lane control block
`include "rlc_params.svh"
package rlc_pkg;
    // One received parallel word with its qualifier
    typedef struct packed {
        logic valid;
        logic [`RLC_WORD_W-1:0] data;
    } rlc_word_t;
    // Per-lane control fields
    typedef struct packed {
        logic align_en;
        logic power_off;
        logic invert;
    } rlc_lane_cfg_t;
    // Word aligner states
    typedef enum logic [1:0] {
        RLC_HUNT = 2'b00,
        RLC_LOCKED = 2'b01,
        RLC_BYPASS = 2'b10
    } rlc_align_state_t;
endpackage

// file: src/rlc_lane_prep.sv
// Lane word preparation: polarity, bit order and octet order
`timescale 1ns/1ps
`include "rlc_params.svh"
module rlc_lane_prep
    import rlc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic invert,
    input wire logic bit_rev,
    input wire logic oct_rev,
    input wire rlc_word_t in_word,
    output rlc_word_t out_word
);
    logic [`RLC_WORD_W-1:0] inv_data;
    logic [`RLC_WORD_W-1:0] brev_data;
    logic [`RLC_WORD_W-1:0] bsel_data;
    logic [`RLC_WORD_W-1:0] orev_data;
    logic [`RLC_WORD_W-1:0] osel_data;
    rlc_word_t out_q;

    assign inv_data = in_word.data ^ {`RLC_WORD_W{invert}};

    for (genvar b = 0; b < `RLC_WORD_W; b++)
    begin : g_brev
        assign brev_data[b] = inv_data[`RLC_WORD_W-1-b];
    end
    assign bsel_data = bit_rev ? brev_data : inv_data;

    for (genvar s = 0; s < `RLC_SYMS; s++)
    begin : g_orev
        assign orev_data[s*`RLC_SYM_W +: `RLC_SYM_W] =
            bsel_data[(`RLC_SYMS-1-s)*`RLC_SYM_W +: `RLC_SYM_W];
    end
    assign osel_data = oct_rev ? orev_data : bsel_data;

    // ==========================================
    // Output register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_q <= '0;
        end
        else
        begin
            out_q.valid <= in_word.valid;
            out_q.data <= osel_data;
        end
    end
    assign out_word = out_q;
endmodule

// file: src/rlc_top.sv
// Receiver lane control: register bank, lane prep and word aligner
`timescale 1ns/1ps
`include "rlc_params.svh"
module rlc_top
    import rlc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RLC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_init,
    input wire rlc_word_t rx_word,
    output rlc_word_t aligned_word,
    output logic align_locked,
    output logic [`RLC_LANES-1:0] lane_power_off
);
    // ==========================================
    // Declarations
    logic setup_phase;
    logic access_phase;
    logic wr_en;
    logic addr_ok;
    logic sel_common;
    logic sel_lane;
    logic sel_status;
    logic [31:0] rd_mux;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic spare_q;
    rlc_lane_cfg_t lane_cfg_q;
    rlc_word_t prep_word;
    logic [`RLC_WORD_W-1:0] prev_q;
    logic [2*`RLC_WORD_W-1:0] window;
    logic [`RLC_WORD_W-1:0] hit;
    logic hit_any;
    logic [`RLC_OFF_W-1:0] hit_off;
    rlc_align_state_t state_q;
    rlc_align_state_t state_d;
    logic [`RLC_OFF_W-1:0] off_q;
    logic [`RLC_OFF_W-1:0] off_d;
    logic link_init_q;
    logic init_rise;
    rlc_word_t out_q;
    logic [`RLC_WORD_W-1:0] shifted;

    // ==========================================
    // APB decode
    // Phases of the transfer
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;

    // Word aligned addresses only
    assign addr_ok = (paddr[1:0] == 2'h0);
    assign sel_common = addr_ok && (paddr == `RLC_COMMON_OFFSET);
    assign sel_lane = addr_ok && (paddr == `RLC_FIRST_LANE_OFFSET);
    assign sel_status = addr_ok && (paddr == `RLC_STATUS_OFFSET);

    // Every transfer completes in its first access cycle
    // Zero wait state slave
    assign pready = 1'b1;

    // Write strobe in the access phase
    assign wr_en = access_phase & pwrite & pstrb[0];

    // ==========================================
    // Read data mux
    always_comb
    begin
        rd_mux = 32'h00000000;
        if (sel_common)
        begin
            rd_mux[`RLC_COMMON_SPARE_BIT] = spare_q;
            rd_mux[`RLC_COMMON_BITREV_BIT] = `RLC_BIT_REVERSAL;
            rd_mux[`RLC_COMMON_OCTREV_BIT] = `RLC_OCTET_REVERSAL;
        end
        else if (sel_lane)
        begin
            rd_mux[`RLC_LANE_ALIGN_BIT] = lane_cfg_q.align_en;
            rd_mux[`RLC_LANE_PWR_BIT] = lane_cfg_q.power_off;
            rd_mux[`RLC_LANE_INV_BIT] = lane_cfg_q.invert;
        end
        // Status reads have no side effects
        else if (sel_status)
        begin
            rd_mux[`RLC_STAT_BYPASS_BIT] = (state_q == RLC_BYPASS);
            rd_mux[`RLC_STAT_LOCK_BIT] = (state_q == RLC_LOCKED);
            rd_mux[`RLC_STAT_OFF_LSB +: `RLC_OFF_W] = off_q;
        end
    end

    // Captured early so the access cycle only gates a register
    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= ~(sel_common | sel_lane | sel_status);
        end
    end

    // Answers shown only in the access phase
    assign prdata = access_phase ? prdata_q : 32'h00000000;
    assign pslverr = access_phase & pslverr_q;

    // ==========================================
    // Common control word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spare_q <= `RLC_COMMON_SPARE_RST;
        end
        else if (wr_en && sel_common)
        begin
            spare_q <= pwdata[`RLC_COMMON_SPARE_BIT];
        end
    end

    // ==========================================
    // First lane control word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lane_cfg_q.align_en <= `RLC_LANE_ALIGN_RST;
            lane_cfg_q.power_off <= `RLC_LANE_PWR_RST;
            lane_cfg_q.invert <= `RLC_LANE_INV_RST;
        end
        else if (wr_en && sel_lane)
        begin
            lane_cfg_q.align_en <= pwdata[`RLC_LANE_ALIGN_BIT];
            lane_cfg_q.power_off <= pwdata[`RLC_LANE_PWR_BIT];
            lane_cfg_q.invert <= pwdata[`RLC_LANE_INV_BIT];
        end
    end

    // ==========================================
    // Power-off export
    // Straight from the register so fallback is seen at once
    // Lane 0 element driven
    assign lane_power_off[0] = lane_cfg_q.power_off;
    // Lanes beyond the first are not built here
    assign lane_power_off[`RLC_LANES-1:1] = '0;

    // ==========================================
    // Lane preparation stage
    // Ordering choices are fixed at build time and fed as constants
    // Common ordering, invert first
    rlc_lane_prep u_prep (
        .pclk(pclk),
        .presetn(presetn),
        .invert(lane_cfg_q.invert),
        .bit_rev(`RLC_BIT_REVERSAL),
        .oct_rev(`RLC_OCTET_REVERSAL),
        .in_word(rx_word),
        .out_word(prep_word)
    );

    // ==========================================
    // Word aligner window
    // Held over idle cycles so a pattern can straddle two words
    // Previous prepared word, earlier bits low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_q <= '0;
        end
        else if (prep_word.valid)
        begin
            prev_q <= prep_word.data;
        end
    end

    // Two words side by side for every bit offset
    assign window = {prep_word.data, prev_q};

    // Pattern search at every bit offset
    for (genvar k = 0; k < `RLC_WORD_W; k++)
    begin : g_hit
        assign hit[k] = (window[k +: `RLC_SYM_W] == `RLC_COMMA_POS) ||
                        (window[k +: `RLC_SYM_W] == `RLC_COMMA_NEG);
    end
    assign hit_any = |hit;

    // Scanned from the top so the lowest hit is left standing
    // Lowest offset that carries the pattern
    always_comb
    begin
        hit_off = '0;
        for (int i = `RLC_WORD_W - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                hit_off = i[`RLC_OFF_W-1:0];
            end
        end
    end

    // ==========================================
    // Link initialization edge
    // Edge only, so a long init phase does not restart the hunt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_init_q <= 1'b0;
        end
        else
        begin
            link_init_q <= link_init;
        end
    end
    assign init_rise = link_init & ~link_init_q;

    // ==========================================
    // Aligner state machine
    // Hunting needs a valid word so idle filler cannot fake a lock
    always_comb
    begin
        state_d = state_q;
        off_d = off_q;
        unique case (state_q)
            RLC_HUNT:
            begin
                if (!lane_cfg_q.align_en)
                begin
                    state_d = RLC_BYPASS;
                    off_d = '0;
                end
                else if (link_init && prep_word.valid && hit_any
                         && !lane_cfg_q.power_off)
                begin
                    state_d = RLC_LOCKED;
                    off_d = hit_off;
                end
            end
            RLC_LOCKED:
            begin
                if (!lane_cfg_q.align_en)
                begin
                    state_d = RLC_BYPASS;
                    off_d = '0;
                end
                // New initialization or lane off restarts search
                else if (init_rise || lane_cfg_q.power_off)
                begin
                    state_d = RLC_HUNT;
                end
            end
            RLC_BYPASS:
            begin
                // Bypass shows the previous word untouched, for slip debug
                // Offset frozen at zero while disabled
                off_d = '0;
                if (lane_cfg_q.align_en)
                begin
                    state_d = RLC_HUNT;
                end
            end
            default:
            begin
                state_d = RLC_HUNT;
                off_d = '0;
            end
        endcase
    end

    // State and offset registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= RLC_HUNT;
            off_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            off_q <= off_d;
        end
    end

    // ==========================================
    // Aligned output word
    // Prep adds one cycle and this register adds the second
    // Slice the window at the locked offset
    assign shifted = window[off_q +: `RLC_WORD_W];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_q <= '0;
        end
        else
        begin
            // Powered-off lane delivers no words
            out_q.valid <= prep_word.valid & ~lane_cfg_q.power_off;
            out_q.data <= shifted;
        end
    end

    assign aligned_word = out_q;
    assign align_locked = (state_q == RLC_LOCKED);
endmodule

// file: sim/rlc_rx_source.sv
// Far-side lane source model feeding received words
`timescale 1ns/1ps
`include "rlc_params.svh"
module rlc_rx_source
    import rlc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic [`RLC_WORD_W-1:0] req_data,
    output rlc_word_t rx_word
);
    // ==========
    // Word launch
    // Idle cycles carry flipped data so a stale word never looks fresh
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_word <= '0;
        else
        begin
            rx_word.valid <= req;
            rx_word.data <= req ? req_data : ~rx_word.data;
        end
    end
endmodule

// file: sim/rlc_top_assertions.sv
// Port-level checks for the receiver lane control block
`timescale 1ns/1ps
`include "rlc_params.svh"
module rlc_top_assertions
    import rlc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RLC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic link_init,
    input wire rlc_word_t rx_word,
    input wire rlc_word_t aligned_word,
    input wire logic align_locked,
    input wire logic [`RLC_LANES-1:0] lane_power_off
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========
    // Bus steps
    sequence s_acc;
        psel && penable && pready;
    endsequence
    sequence s_rd_common;
        s_acc ##0 !pwrite && paddr == `RLC_COMMON_OFFSET;
    endsequence
    sequence s_rd_lane;
        s_acc ##0 !pwrite && paddr == `RLC_FIRST_LANE_OFFSET;
    endsequence
    sequence s_wr_lane;
        s_acc ##0 pwrite && pstrb[0] && paddr == `RLC_FIRST_LANE_OFFSET;
    endsequence
    // ==========
    // Register checks
    property p_common_rsv;
        s_rd_common |-> prdata[31:3] == 29'h0;
    endproperty
    a_common_rsv: assert property (p_common_rsv) else $error("common reserved set");
    property p_common_ro;
        s_rd_common |-> prdata[1:0] == 2'h3;
    endproperty
    a_common_ro: assert property (p_common_ro) else $error("order bits changed");
    property p_lane_rd;
        s_rd_lane |-> prdata[31:3] == 29'h0 && prdata[1] == lane_power_off[0];
    endproperty
    a_lane_rd: assert property (p_lane_rd) else $error("lane word readback");
    property p_pwr_wr;
        s_wr_lane |=> lane_power_off[0] == $past(pwdata[1]);
    endproperty
    a_pwr_wr: assert property (p_pwr_wr) else $error("power bit not exported");
    property p_pwr_vec;
        lane_power_off[3:1] == 3'h0;
    endproperty
    a_pwr_vec: assert property (p_pwr_vec) else $error("unused power bits set");
    // ==========
    // Data path checks
    property p_pwr_gate;
        lane_power_off[0] && $past(lane_power_off[0]) |-> !aligned_word.valid;
    endproperty
    a_pwr_gate: assert property (p_pwr_gate) else $error("word out while off");
    property p_latency;
        aligned_word.valid |-> $past(rx_word.valid, 2);
    endproperty
    a_latency: assert property (p_latency) else $error("word without input");
    property p_fill;
        $past(rx_word.valid, 2) && !$past(lane_power_off[0]) |-> aligned_word.valid;
    endproperty
    a_fill: assert property (p_fill) else $error("word lost");
    property p_lock_src;
        $rose(align_locked) |-> $past(link_init) && !$past(lane_power_off[0]);
    endproperty
    a_lock_src: assert property (p_lock_src) else $error("lock outside init");
    property p_lock_drop;
        $rose(lane_power_off[0]) |-> ##[0:3] !align_locked;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock kept at off");
endmodule
bind rlc_top rlc_top_assertions chk (.*);

// file: sim/test_rx_lane_control.sv
// Self-checking bench for the receiver lane control block
`timescale 1ns/1ps
`include "rlc_params.svh"
module test_rx_lane_control
    import rlc_pkg::*;
;
    // ==========
    // Signals
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pready, pslverr;
    logic link_init = '0, req = '0, align_locked, pv = '0, ev = '0, cmp = '0, inv = '0;
    logic pwr = '0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = '0, lane_power_off;
    logic [39:0] req_data = '0, pd = '0, pprev = '0, ed = '0;
    logic [79:0] cat;
    int num_errors = 0, n_checks = 0, off = 0;
    rlc_word_t rx_word, aligned_word;
    rlc_rx_source src (.*);
    rlc_top uut (.*);
    // Clock
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    // Each symbol mirrored in place: full reversal then symbol swap
    function automatic logic [39:0] prep(logic [39:0] x);
        for (int i = 0; i < 40; i++)
            prep[i] = x[i - 2 * (i % 10) + 9];
    endfunction
    task automatic chk(string n, logic [40:0] e, logic [40:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // Reference pipeline: prepare, then slice at the expected offset
    always @(posedge pclk)
    begin
        if (cmp)
            chk("aligned", {ev, ed}, {aligned_word.valid, ev ? aligned_word.data : ed});
        cat = {pd, pprev} >> off;
        ed <= cat[39:0];
        ev <= pv & !pwr;
        if (pv)
            pprev <= pd;
        pv <= rx_word.valid;
        pd <= prep(rx_word.data ^ {40{inv}});
    end
    // One bus transfer, held until pready
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rchk(string n, logic [11:0] a, logic [31:0] e, logic ee);
        apb(1'h0, a, 32'h0, 4'hF);
        chk(n, e, rd);
        chk({n, " err"}, ee, err);
    endtask
    task automatic stream(int n, logic [39:0] b, logic [39:0] s);
        for (int i = 0; i < n; i++)
        begin
            @(posedge pclk);
            req <= 1'h1;
            req_data <= b + s * i;
        end
        @(posedge pclk);
        req <= 1'h0;
    endtask
    // ==========
    // Scenarios
    task automatic t_regs;
        rchk("common rst", 12'h000, 32'h3, 1'h0);
        rchk("lane rst", 12'h004, 32'h4, 1'h0);
        apb(1'h1, 12'h000, 32'hFFFF_FFFF, 4'hF);
        rchk("common set", 12'h000, 32'h7, 1'h0);
        apb(1'h1, 12'h000, 32'h0, 4'hF);
        rchk("common clr", 12'h000, 32'h3, 1'h0);
        apb(1'h1, 12'h004, 32'h7, 4'h0);
        apb(1'h1, 12'h006, 32'h7, 4'hF);
        chk("misaligned err", 1'h1, err);
        rchk("lane kept", 12'h004, 32'h4, 1'h0);
        rchk("unmapped", 12'h020, 32'h0, 1'h1);
        $display("t_regs done");
    endtask
    task automatic t_data;
        apb(1'h1, 12'h004, 32'h0, 4'h1);
        rchk("status bypass", 12'h040, 32'h200, 1'h0);
        stream(6, 40'hA5_0F3C_9617, 40'h13_579B_DF02);
        apb(1'h1, 12'h004, 32'h1, 4'h1);
        inv <= 1'h1;
        stream(6, 40'h80_0000_0001, 40'h2E_6A1C_45F3);
        apb(1'h1, 12'h004, 32'h0, 4'h1);
        inv <= 1'h0;
        stream(2, 40'h0, 40'h0);
        $display("t_data done");
    endtask
    task automatic t_align;
        link_init <= 1'h1;
        // Alignment left on for normal use
        apb(1'h1, 12'h004, 32'h4, 4'h1);
        cmp <= 1'h0;
        stream(1, prep(40'h00_0000_1F40), 40'h0);
        stream(2, 40'h0, 40'h0);
        for (int i = 0; i < 8 && align_locked !== 1'h1; i++)
            @(posedge pclk);
        chk("locked", 1'h1, align_locked);
        off = 5;
        rchk("status locked", 12'h040, 32'h105, 1'h0);
        repeat (3) @(posedge pclk);
        cmp <= 1'h1;
        stream(6, 40'h3C_5AA5_0FF0, 40'h1F_0E1D_2C3B);
        $display("t_align done");
    endtask
    task automatic t_pwr;
        apb(1'h1, 12'h004, 32'h6, 4'h1);
        pwr <= 1'h1;
        #1;
        chk("power vec", 4'h1, lane_power_off);
        rchk("lane off", 12'h004, 32'h6, 1'h0);
        rchk("status hunt", 12'h040, 32'h5, 1'h0);
        // Off lane keeps running but gates its words and cannot lock; source still sends
        stream(4, 40'h12_3456_789A, 40'h11_1111_1111);
        chk("unlocked", 1'h0, align_locked);
        $display("t_pwr done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        end_of_test;
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        cmp <= 1'h1;
        t_regs;
        t_data;
        t_align;
        repeat (4) @(posedge pclk);
        t_pwr;
        repeat (4) @(posedge pclk);
        end_of_test;
    end
endmodule
